// ==== rtl/sfps_pkg.sv ====
// Purpose: Shared constants, types and decode helpers for the serial flash
//          protocol, configuration and status block.
// Assumes: System clock at 40 MHz; link clock supplied by the bus master.
// Notes:   Opcodes and busy times are local choices, not fixed by the serial bus.
// Functional notes
// - Device starts in extended protocol; command on lane zero only.
// - Enhanced volatile write with bit6=0, bit7=1 selects two-lane protocol at once.
// - Enhanced volatile write with bit7=0 selects four-lane protocol at once.
// - Volatile protocol choice lost at power-on; a warm boot restores the nonvolatile default.
// - Nonvolatile config bit2=0 boots into two-lane protocol.
// - Nonvolatile config bit3=0 boots into four-lane protocol.
// - Each boot loads the working configuration from the nonvolatile configuration.
// - Volatile and enhanced volatile writes update the working configuration at once.
// - Status bit7=1 with protect pin low blocks status writes.
// - Status bit5 anchors the protected region at top (0) or bottom (1).
// - Write enable latch cleared at power-up; required before any write operation.
// - Status bit0 reads busy during status, config, program or erase cycles.
// - Volatile status bits clear on power cycle or reset.
// - Whole-array erase runs only when all block protect bits are zero.
// - Nonvolatile bits 2 and 3 both zero boot four-lane, overriding two-lane.
// - Inputs sampled on rising link clock, outputs launched on falling edge.
package sfps_pkg;

  // ----------------------------------------------------------------------
  // Protocol and working configuration
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {SFPS_MODE_EXT, SFPS_MODE_DUAL, SFPS_MODE_QUAD} sfps_mode_t;

  // ----------------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------------
  localparam logic [7:0] OP_WR_ENABLE = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE = 8'h04;
  localparam logic [7:0] OP_RD_STATUS = 8'h05;
  localparam logic [7:0] OP_WR_STATUS = 8'h01;
  localparam logic [7:0] OP_WR_VCFG = 8'h81;
  localparam logic [7:0] OP_WR_EVCFG = 8'h61;
  localparam logic [7:0] OP_WR_NVCFG = 8'hb1;
  localparam logic [7:0] OP_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SECT_ERASE = 8'hd8;
  localparam logic [7:0] OP_BULK_ERASE = 8'hc7;

  // ----------------------------------------------------------------------
  // Status word layout and reset values
  // ----------------------------------------------------------------------
  localparam int SR_SRWD = 7;
  localparam int SR_BP3 = 6;
  localparam int SR_TB = 5;
  localparam int SR_BP2 = 4;
  localparam int SR_BP0 = 2;
  localparam int SR_WEL = 1;
  localparam int SR_WIP = 0;
  localparam logic [7:0] SR_NV_MASK = 8'hfc;
  localparam logic [7:0] SR_RESET = 8'h00;

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  localparam int NVCFG_DUAL_N = 2;
  localparam int NVCFG_QUAD_N = 3;
  localparam int NVCFG_DUMMY_LSB = 12;
  localparam int EVCFG_DUAL_N = 6;
  localparam int EVCFG_QUAD_N = 7;
  localparam int VCFG_DUMMY_LSB = 4;
  localparam logic [15:0] NVCFG_RESET = 16'hffff;
  localparam logic [7:0] VCFG_RESET = 8'hfb;
  localparam logic [7:0] EVCFG_RESET = 8'hff;

  // ----------------------------------------------------------------------
  // Array protection geometry
  // ----------------------------------------------------------------------
  localparam int SECT_LSB = 16;
  localparam logic [7:0] SECT_COUNT = 8'h80;
  localparam logic [3:0] BP_ALL = 4'h8;

  // ----------------------------------------------------------------------
  // Busy times and their cycle counts
  // ----------------------------------------------------------------------
  localparam int unsigned SYS_CLK_MHZ = 40;
  localparam int unsigned T_STATUS_WR_NS = 5000;
  localparam int unsigned T_NVCFG_WR_NS = 5000;
  localparam int unsigned T_PROGRAM_NS = 2000;
  localparam int unsigned T_ERASE_NS = 10000;
  localparam logic [15:0] CYC_STATUS_WR = 16'((T_STATUS_WR_NS * SYS_CLK_MHZ + 999) / 1000);
  localparam logic [15:0] CYC_NVCFG_WR = 16'((T_NVCFG_WR_NS * SYS_CLK_MHZ + 999) / 1000);
  localparam logic [15:0] CYC_PROGRAM = 16'((T_PROGRAM_NS * SYS_CLK_MHZ + 999) / 1000);
  localparam logic [15:0] CYC_ERASE = 16'((T_ERASE_NS * SYS_CLK_MHZ + 999) / 1000);

  // Bytes in a frame, opcode included, after which a command is handed over
  function automatic logic [2:0] sfps_cmd_len(input logic [7:0] op);
    unique case (op)
      OP_WR_ENABLE, OP_WR_DISABLE, OP_BULK_ERASE: sfps_cmd_len = 3'h1;
      OP_WR_STATUS, OP_WR_VCFG, OP_WR_EVCFG: sfps_cmd_len = 3'h2;
      OP_WR_NVCFG: sfps_cmd_len = 3'h3;
      OP_PROGRAM, OP_SECT_ERASE: sfps_cmd_len = 3'h4;
      default: sfps_cmd_len = 3'h0;
    endcase
  endfunction : sfps_cmd_len

  function automatic sfps_mode_t sfps_evcfg_mode(input logic [7:0] v);
    if (!v[EVCFG_QUAD_N]) begin
      sfps_evcfg_mode = SFPS_MODE_QUAD;
    end else if (!v[EVCFG_DUAL_N]) begin
      sfps_evcfg_mode = SFPS_MODE_DUAL;
    end else begin
      sfps_evcfg_mode = SFPS_MODE_EXT;
    end
  endfunction : sfps_evcfg_mode

  function automatic sfps_mode_t sfps_nvcfg_mode(input logic [15:0] v);
    if (!v[NVCFG_QUAD_N]) begin
      sfps_nvcfg_mode = SFPS_MODE_QUAD;
    end else if (!v[NVCFG_DUAL_N]) begin
      sfps_nvcfg_mode = SFPS_MODE_DUAL;
    end else begin
      sfps_nvcfg_mode = SFPS_MODE_EXT;
    end
  endfunction : sfps_nvcfg_mode

endpackage : sfps_pkg

// ==== rtl/sfps_link_if.sv ====
// Purpose: Carrier between the link-clock lane engine and the system core.
// Assumes: Command words held stable between toggles of evt_tgl.
// Notes:   status and mode are quasi-static and resynchronised by the engine.
`timescale 1ns/1ps
interface sfps_link_if;
  import sfps_pkg::*;
  logic evt_tgl;
  logic [7:0] cmd_op;
  logic [23:0] cmd_arg;
  logic [7:0] status;
  sfps_mode_t mode;

  modport link (output evt_tgl, output cmd_op, output cmd_arg, input status, input mode);
  modport core (input evt_tgl, input cmd_op, input cmd_arg, output status, output mode);
endinterface : sfps_link_if

// ==== rtl/sfps_lane_engine.sv ====
// Purpose: Serial frame engine on the link clock: shifts commands in on the
//          active lane count and shifts the status word out.
// Assumes: Link clock only runs while chip select is low.
// Notes:   Chip select high clears the frame state asynchronously.
`timescale 1ns/1ps
module sfps_lane_engine
  import sfps_pkg::*;
(
  // Clocks and resets
  input wire logic spi_clk_in,
  input wire logic sys_rst_in,
  // Serial pins
  input wire logic cs_n_in,
  input wire logic [3:0] lane_in,
  output logic [3:0] lane_out,
  output logic [3:0] lane_oe_out,
  // Core side
  sfps_link_if.link lk
);

  typedef struct packed {
    sfps_mode_t mode_s1;
    sfps_mode_t mode_s2;
    logic [7:0] stat_s1;
    logic [7:0] stat_s2;
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [7:0] shift;
    logic [7:0] op;
    logic [23:0] arg;
    logic evt_tgl;
    logic rd_on;
  } sfps_rx_t;

  typedef struct packed {
    logic [7:0] shift;
    logic [2:0] cnt;
    logic [3:0] dq;
    logic [3:0] oe;
  } sfps_tx_t;

  sfps_rx_t rx_q;
  sfps_rx_t rx_d;
  sfps_tx_t tx_q;
  sfps_tx_t tx_d;
  logic in_frame_q;
  logic frame_rst;

  // A frame ends with chip select, as the link clock stops outside frames
  assign frame_rst = sys_rst_in | cs_n_in;

  // ----------------------------------------------------------------------
  // Receive on the rising edge
  // ----------------------------------------------------------------------
  always_comb begin
    logic [2:0] bc;
    logic [2:0] yc;
    logic [3:0] nb;
    logic [7:0] sh;
    bc = in_frame_q ? rx_q.bit_cnt : 3'h0;
    yc = in_frame_q ? rx_q.byte_cnt : 3'h0;
    nb = 4'h0;
    sh = rx_q.shift;
    rx_d = rx_q;
    rx_d.mode_s1 = sfps_mode_t'(lk.mode);
    rx_d.mode_s2 = rx_q.mode_s1;
    rx_d.stat_s1 = lk.status;
    rx_d.stat_s2 = rx_q.stat_s1;
    if (!in_frame_q) begin
      rx_d.rd_on = 1'b0;
    end
    unique case (rx_q.mode_s2)
      SFPS_MODE_EXT: begin
        sh = {rx_q.shift[6:0], lane_in[0]};
        nb = {1'b0, bc} + 4'h1;
      end
      SFPS_MODE_DUAL: begin
        sh = {rx_q.shift[5:0], lane_in[1:0]};
        nb = {1'b0, bc} + 4'h2;
      end
      SFPS_MODE_QUAD: begin
        sh = {rx_q.shift[3:0], lane_in[3:0]};
        nb = {1'b0, bc} + 4'h4;
      end
      default: begin
        sh = rx_q.shift;
        nb = {1'b0, bc};
      end
    endcase
    rx_d.shift = sh;
    rx_d.bit_cnt = nb[2:0];
    rx_d.byte_cnt = yc;
    if (nb[3]) begin
      if (yc == 3'h0) begin
        rx_d.op = sh;
        rx_d.rd_on = (sh == OP_RD_STATUS);
        if (sfps_cmd_len(sh) == 3'h1) begin
          rx_d.evt_tgl = ~rx_q.evt_tgl;
        end
      end else if (yc < 3'h4) begin
        unique case (yc)
          3'h1: rx_d.arg[23:16] = sh;
          3'h2: rx_d.arg[15:8] = sh;
          default: rx_d.arg[7:0] = sh;
        endcase
        if (sfps_cmd_len(rx_q.op) == yc + 3'h1) begin
          rx_d.evt_tgl = ~rx_q.evt_tgl;
        end
      end
      // Trailing bytes such as program data are counted out and dropped
      if (yc < 3'h4) begin
        rx_d.byte_cnt = yc + 3'h1;
      end
    end
  end

  always_ff @(posedge spi_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rx_q <= '{mode_s1: SFPS_MODE_EXT, mode_s2: SFPS_MODE_EXT, default: '0};
    end else begin
      rx_q <= rx_d;
    end
  end

  always_ff @(posedge spi_clk_in or posedge frame_rst) begin
    if (frame_rst) begin
      in_frame_q <= 1'b0;
    end else begin
      in_frame_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Transmit on the falling edge
  // ----------------------------------------------------------------------
  always_comb begin
    logic [7:0] src;
    src = (tx_q.cnt == 3'h0) ? rx_q.stat_s2 : tx_q.shift;
    tx_d = '0;
    if (rx_q.rd_on) begin
      unique case (rx_q.mode_s2)
        SFPS_MODE_EXT: begin
          tx_d.dq = {2'b00, src[7], 1'b0};
          tx_d.oe = 4'b0010;
          tx_d.shift = {src[6:0], 1'b0};
          tx_d.cnt = tx_q.cnt + 3'h1;
        end
        SFPS_MODE_DUAL: begin
          tx_d.dq = {2'b00, src[7:6]};
          tx_d.oe = 4'b0011;
          tx_d.shift = {src[5:0], 2'b00};
          tx_d.cnt = tx_q.cnt + 3'h2;
        end
        SFPS_MODE_QUAD: begin
          tx_d.dq = src[7:4];
          tx_d.oe = 4'b1111;
          tx_d.shift = {src[3:0], 4'h0};
          tx_d.cnt = tx_q.cnt + 3'h4;
        end
        default: tx_d = '0;
      endcase
    end
  end

  always_ff @(negedge spi_clk_in or posedge frame_rst) begin
    if (frame_rst) begin
      tx_q <= '0;
    end else begin
      tx_q <= tx_d;
    end
  end

  assign lane_out = tx_q.dq;
  assign lane_oe_out = tx_q.oe;
  assign lk.evt_tgl = rx_q.evt_tgl;
  assign lk.cmd_op = rx_q.op;
  assign lk.cmd_arg = rx_q.arg;

endmodule : sfps_lane_engine

// ==== rtl/sfps_core.sv ====
// Purpose: Top of the serial flash protocol, configuration and status block.
//          Holds status, configuration and working registers and executes
//          commands handed over from the link-clock lane engine.
// Assumes: sys_rst_in is the power-on reset; soft_boot_in a warm boot request.
// Notes:   No storage array is modelled; program and erase only run busy time.
`timescale 1ns/1ps
module sfps_core
  import sfps_pkg::*;
(
  // System clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Serial link
  input wire logic spi_clk_in,
  input wire logic cs_n_in,
  input wire logic [3:0] lane_in,
  output logic [3:0] lane_out,
  output logic [3:0] lane_oe_out,
  // Protect and boot pins
  input wire logic wp_n_in,
  input wire logic soft_boot_in,
  // Working configuration
  output logic [1:0] protocol_mode_out,
  output logic [3:0] dummy_cycles_out
);

  typedef enum logic [1:0] {ST_BOOT, ST_IDLE, ST_BUSY} sfps_core_st_t;

  typedef struct packed {
    logic [1:0] wp_sync;
    logic [1:0] boot_sync;
    logic boot_prev;
    logic [2:0] tgl_sync;
    sfps_core_st_t st;
    logic [7:0] status;
    logic [15:0] nvcfg;
    logic [7:0] vcfg;
    logic [7:0] evcfg;
    sfps_mode_t mode;
    logic [3:0] dummy;
    logic [15:0] busy_cnt;
  } sfps_core_t;

  sfps_core_t core_q;
  sfps_core_t core_d;

  sfps_link_if lk ();

  sfps_lane_engine u_lane_engine (
    .spi_clk_in(spi_clk_in),
    .sys_rst_in(sys_rst_in),
    .cs_n_in(cs_n_in),
    .lane_in(lane_in),
    .lane_out(lane_out),
    .lane_oe_out(lane_oe_out),
    .lk(lk.link)
  );

  // ----------------------------------------------------------------------
  // Protected region decode
  // ----------------------------------------------------------------------
  function automatic logic sect_protected(input logic [3:0] bp, input logic tb,
                                          input logic [6:0] sect);
    logic [7:0] size;
    logic [7:0] s8;
    size = 8'h00;
    s8 = {1'b0, sect};
    if (bp >= BP_ALL) begin
      size = SECT_COUNT;
    end else if (bp != 4'h0) begin
      size = 8'h01 << (bp - 4'h1);
    end
    if (tb) begin
      sect_protected = (s8 < size);
    end else begin
      sect_protected = (s8 >= SECT_COUNT - size);
    end
  endfunction : sect_protected

  // ----------------------------------------------------------------------
  // Command execution
  // ----------------------------------------------------------------------
  always_comb begin
    logic evt;
    logic boot_req;
    logic wel;
    logic [3:0] bp;
    logic [7:0] arg0;
    evt = core_q.tgl_sync[2] ^ core_q.tgl_sync[1];
    boot_req = core_q.boot_sync[1] & ~core_q.boot_prev;
    wel = core_q.status[SR_WEL];
    bp = {core_q.status[SR_BP3], core_q.status[SR_BP2:SR_BP0]};
    arg0 = lk.cmd_arg[23:16];
    core_d = core_q;
    core_d.wp_sync = {core_q.wp_sync[0], wp_n_in};
    core_d.boot_sync = {core_q.boot_sync[0], soft_boot_in};
    core_d.boot_prev = core_q.boot_sync[1];
    core_d.tgl_sync = {core_q.tgl_sync[1:0], lk.evt_tgl};
    unique case (core_q.st)
      ST_BOOT: begin
        core_d.mode = sfps_nvcfg_mode(core_q.nvcfg);
        core_d.dummy = core_q.nvcfg[NVCFG_DUMMY_LSB +: 4];
        core_d.evcfg = EVCFG_RESET;
        core_d.vcfg = VCFG_RESET;
        core_d.st = ST_IDLE;
      end
      ST_IDLE: begin
        if (evt) begin
          // Write commands without the enable latch fall through untouched
          case (lk.cmd_op)
            OP_WR_ENABLE: begin
              core_d.status[SR_WEL] = 1'b1;
            end
            OP_WR_DISABLE: begin
              core_d.status[SR_WEL] = 1'b0;
            end
            OP_WR_STATUS: begin
              if (wel && !(core_q.status[SR_SRWD] && !core_q.wp_sync[1])) begin
                core_d.status = (arg0 & SR_NV_MASK) | (core_q.status & ~SR_NV_MASK);
                core_d.status[SR_WIP] = 1'b1;
                core_d.busy_cnt = CYC_STATUS_WR;
                core_d.st = ST_BUSY;
              end
            end
            OP_WR_VCFG: begin
              if (wel) begin
                core_d.vcfg = arg0;
                core_d.dummy = arg0[VCFG_DUMMY_LSB +: 4];
                core_d.status[SR_WEL] = 1'b0;
              end
            end
            OP_WR_EVCFG: begin
              if (wel) begin
                core_d.evcfg = arg0;
                core_d.mode = sfps_evcfg_mode(arg0);
                core_d.status[SR_WEL] = 1'b0;
              end
            end
            OP_WR_NVCFG: begin
              // Takes effect only at the next warm boot, not on the working copy
              if (wel) begin
                core_d.nvcfg = {lk.cmd_arg[15:8], arg0};
                core_d.status[SR_WIP] = 1'b1;
                core_d.busy_cnt = CYC_NVCFG_WR;
                core_d.st = ST_BUSY;
              end
            end
            OP_PROGRAM, OP_SECT_ERASE: begin
              if (wel && !sect_protected(bp, core_q.status[SR_TB],
                                         lk.cmd_arg[SECT_LSB +: 7])) begin
                core_d.status[SR_WIP] = 1'b1;
                core_d.busy_cnt = (lk.cmd_op == OP_PROGRAM) ? CYC_PROGRAM : CYC_ERASE;
                core_d.st = ST_BUSY;
              end
            end
            OP_BULK_ERASE: begin
              if (wel && bp == 4'h0) begin
                core_d.status[SR_WIP] = 1'b1;
                core_d.busy_cnt = CYC_ERASE;
                core_d.st = ST_BUSY;
              end
            end
            default: begin
              core_d.st = ST_IDLE;
            end
          endcase
        end
      end
      ST_BUSY: begin
        // Commands arriving now are dropped; the host polls the busy bit
        if (core_q.busy_cnt <= 16'h0001) begin
          core_d.busy_cnt = 16'h0000;
          core_d.status[SR_WIP] = 1'b0;
          core_d.status[SR_WEL] = 1'b0;
          core_d.st = ST_IDLE;
        end else begin
          core_d.busy_cnt = core_q.busy_cnt - 16'h0001;
        end
      end
    endcase
    // Warm boot aborts any cycle and reloads from the nonvolatile copy
    if (boot_req) begin
      core_d.status[SR_WEL] = 1'b0;
      core_d.status[SR_WIP] = 1'b0;
      core_d.busy_cnt = 16'h0000;
      core_d.st = ST_BOOT;
    end
  end

  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      core_q <= '{st: ST_BOOT, status: SR_RESET, nvcfg: NVCFG_RESET,
                  vcfg: VCFG_RESET, evcfg: EVCFG_RESET, mode: SFPS_MODE_EXT,
                  default: '0};
    end else begin
      core_q <= core_d;
    end
  end

  assign lk.status = core_q.status;
  assign lk.mode = core_q.mode;
  assign protocol_mode_out = core_q.mode;
  assign dummy_cycles_out = core_q.dummy;

endmodule : sfps_core

// ==== sim/sfps_properties.sv ====
// Purpose: Port-level checks on the flash protocol and status block.
// Assumes: Link clock stands still outside frames; sys_rst_in is the only reset.
// Notes: Working settings may move only just after a frame or a boot request.
`timescale 1ns/1ps
module sfps_properties
  import sfps_pkg::*;
(
  // Clocks and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic spi_clk_in,
  // Link pins
  input wire logic cs_n_in,
  input wire logic [3:0] lane_out,
  input wire logic [3:0] lane_oe_out,
  // Boot pin and working settings
  input wire logic soft_boot_in,
  input wire logic [1:0] protocol_mode_out,
  input wire logic [3:0] dummy_cycles_out
);
  logic [3:0] quiet_q;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  // Cycles since the last frame or boot request, saturating
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      quiet_q <= 4'h0;
    end else if (!cs_n_in || soft_boot_in) begin
      quiet_q <= 4'h0;
    end else if (quiet_q != 4'hf) begin
      quiet_q <= quiet_q + 4'h1;
    end
  end
  sequence s_open;
    $fell(cs_n_in);
  endsequence
  sequence s_silent;
    lane_oe_out == 4'h0 [*8];
  endsequence
  a_boot_idle: assert property ($fell(sys_rst_in) |-> protocol_mode_out == 2'h0)
    else $error("mode not idle at reset exit");
  a_oe_idle: assert property (cs_n_in |-> lane_oe_out == 4'h0)
    else $error("lanes driven while deselected");
  a_mode_legal: assert property (protocol_mode_out != 2'h3)
    else $error("undefined protocol mode");
  a_oe_width: assert property (lane_oe_out != 4'h0 |-> lane_oe_out ==
    (protocol_mode_out[1] ? 4'hf : protocol_mode_out[0] ? 4'h3 : 4'h2))
    else $error("drive width differs from protocol");
  // Output launch on the falling edge leaves the clock low for half a period
  a_launch_fall: assert property (!cs_n_in && !$past(cs_n_in) && $changed(lane_out)
    |-> !spi_clk_in)
    else $error("lane output moved while link clock high");
  a_mode_quiet: assert property ($changed(protocol_mode_out) |-> quiet_q < 4'h8)
    else $error("mode moved away from a frame or boot");
  a_dummy_quiet: assert property ($changed(dummy_cycles_out) |-> quiet_q < 4'h8)
    else $error("dummy setting moved away from a frame or boot");
  a_oe_late: assert property (s_open |-> s_silent)
    else $error("lanes driven before opcode complete");
endmodule : sfps_properties
bind sfps_core sfps_properties u_props (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
  .spi_clk_in(spi_clk_in), .cs_n_in(cs_n_in), .lane_out(lane_out),
  .lane_oe_out(lane_oe_out), .soft_boot_in(soft_boot_in),
  .protocol_mode_out(protocol_mode_out), .dummy_cycles_out(dummy_cycles_out));

// ==== sim/sfps_host.sv ====
// Purpose: Host controller model on the far side of the flash link.
// Assumes: Link clock idles low and stands still between frames.
// Notes: Released lanes carry the inverse of the last value sent.
`timescale 1ns/1ps
module sfps_host
  import sfps_pkg::*;
(
  // Link pins
  output logic spi_clk_out,
  output logic cs_n_out,
  output logic [3:0] lane_out,
  input wire logic [3:0] wire_in
);
  sfps_mode_t mode_q = SFPS_MODE_EXT;
  initial begin
    spi_clk_out = 1'b0;
    cs_n_out = 1'b1;
    lane_out = 4'h0;
  end
  task automatic xfer(input logic [31:0] d, input int n, input bit rd, output logic [7:0] st);
    int w;
    w = (mode_q == SFPS_MODE_QUAD) ? 4 : (mode_q == SFPS_MODE_DUAL) ? 2 : 1;
    st = 8'h00;
    cs_n_out <= 1'b0;
    for (int i = 0; i < n * 8 / w; i++) begin
      lane_out <= 4'(d[31:28] >> (4 - w));
      d = d << w;
      #80 spi_clk_out <= 1'b1;
      #80 spi_clk_out <= 1'b0;
    end
    lane_out <= ~lane_out;
    for (int i = 0; rd && i < 8 / w; i++) begin
      #80 spi_clk_out <= 1'b1;
      st = (st << w) | 8'((w == 1) ? {3'h0, wire_in[1]} : wire_in & 4'((1 << w) - 1));
      #80 spi_clk_out <= 1'b0;
    end
    #80 cs_n_out <= 1'b1;
    #400;
  endtask : xfer
endmodule : sfps_host

// ==== sim/serial_flash_protocol_status_tb.sv ====
// Purpose: Self-checking bench for the flash protocol and status block.
// Assumes: The host model drives every frame on the link.
// Notes: Program busy ends inside one status read, so only its end is checked.
`timescale 1ns/1ps
module serial_flash_protocol_status_tb
  import sfps_pkg::*;
;
  logic sys_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic wp_n_in = 1'b1;
  logic soft_boot_in = 1'b0;
  logic sck, cs_n;
  logic [3:0] h_lane, d_lane, d_oe, lane, dummy;
  logic [1:0] mode;
  logic [7:0] st;
  logic [7:0] ev [3] = '{8'hbf, 8'h7f, 8'hff};
  logic [1:0] em [3] = '{2'h1, 2'h2, 2'h0};
  logic [15:0] nv [3] = '{16'hfffb, 16'hfff7, 16'hfff3};
  logic [1:0] bm [3] = '{2'h1, 2'h2, 2'h2};
  int errors = 0;
  int num_checks = 0;
  // Device drive wins on a lane it enables; the host fills the rest
  assign lane = (d_oe & d_lane) | (~d_oe & h_lane);
  always #12.5 sys_clk_in = ~sys_clk_in;
  sfps_core DUT (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .spi_clk_in(sck),
    .cs_n_in(cs_n), .lane_in(lane), .lane_out(d_lane), .lane_oe_out(d_oe),
    .wp_n_in(wp_n_in), .soft_boot_in(soft_boot_in), .protocol_mode_out(mode),
    .dummy_cycles_out(dummy));
  sfps_host u_host (.spi_clk_out(sck), .cs_n_out(cs_n), .lane_out(h_lane), .wire_in(lane));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : give_verdict
  task automatic ticks(input int n);
    repeat (n) @(posedge sys_clk_in);
  endtask : ticks
  task automatic cmd(input logic [31:0] data, input int n);
    logic [7:0] dump;
    u_host.xfer(data, n, 1'b0, dump);
  endtask : cmd
  task automatic wr(input logic [31:0] data, input int n);
    cmd({OP_WR_ENABLE, 24'h0}, 1);
    cmd(data, n);
  endtask : wr
  task automatic rdsr();
    u_host.xfer({OP_RD_STATUS, 24'h0}, 1, 1'b1, st);
  endtask : rdsr
  task automatic wait_ready();
    for (int i = 0; i < 20; i++) begin
      rdsr();
      if (st[SR_WIP] === 1'b0) return;
    end
    errors++;
    give_verdict();
  endtask : wait_ready
  // Mode resync runs on the link clock, so a throwaway frame follows each change
  task automatic follow(input logic [1:0] m);
    u_host.mode_q = sfps_mode_t'(m);
    cmd(32'hff000000, 1);
  endtask : follow
  initial begin
    ticks(8);
    sys_rst_in <= 1'b0;
    ticks(4);
    check("mode", 8'(mode), 8'h00);
    check("dummy", 8'(dummy), 8'h0f);
    rdsr();
    check("status", st, SR_RESET);
    cmd({OP_WR_STATUS, 8'h84, 16'h0}, 2);
    rdsr();
    check("status", st, 8'h00);
    cmd({OP_WR_ENABLE, 24'h0}, 1);
    cmd({OP_WR_DISABLE, 24'h0}, 1);
    rdsr();
    check("status", st, 8'h00);
    cmd({OP_WR_ENABLE, 24'h0}, 1);
    rdsr();
    check("status", st, 8'h02);
    $display("test latch done");
    cmd({OP_WR_STATUS, 8'h84, 16'h0}, 2);
    rdsr();
    check("busy", st & 8'h03, 8'h03);
    wait_ready();
    check("status", st, 8'h84);
    wr({OP_BULK_ERASE, 24'h0}, 1);
    rdsr();
    check("status", st, 8'h86);
    @(posedge sys_clk_in);
    wp_n_in <= 1'b0;
    ticks(4);
    cmd({OP_WR_STATUS, 24'h0}, 2);
    rdsr();
    check("status", st, 8'h86);
    @(posedge sys_clk_in);
    wp_n_in <= 1'b1;
    ticks(4);
    cmd({OP_WR_STATUS, 24'h0}, 2);
    wait_ready();
    check("status", st, 8'h00);
    wr({OP_BULK_ERASE, 24'h0}, 1);
    rdsr();
    check("busy", st, 8'h03);
    wait_ready();
    $display("test protect done");
    wr({OP_WR_STATUS, 8'h24, 16'h0}, 2);
    wait_ready();
    wr({OP_PROGRAM, 24'h000000}, 4);
    rdsr();
    check("status", st, 8'h26);
    cmd({OP_PROGRAM, 24'h7f0000}, 4);
    wait_ready();
    check("status", st, 8'h24);
    wr({OP_SECT_ERASE, 24'h400000}, 4);
    rdsr();
    check("busy", st, 8'h27);
    wait_ready();
    wr({OP_WR_STATUS, 8'h04, 16'h0}, 2);
    wait_ready();
    wr({OP_PROGRAM, 24'h7f0000}, 4);
    rdsr();
    check("status", st, 8'h06);
    wr({OP_WR_STATUS, 8'h24, 16'h0}, 2);
    wait_ready();
    check("status", st, 8'h24);
    $display("test region done");
    foreach (ev[i]) begin
      wr({OP_WR_EVCFG, ev[i], 16'h0}, 2);
      check("mode", 8'(mode), 8'(em[i]));
      follow(em[i]);
      rdsr();
      check("status", st, 8'h24);
    end
    wr({OP_WR_VCFG, 8'h5b, 16'h0}, 2);
    check("dummy", 8'(dummy), 8'h05);
    $display("test modes done");
    foreach (nv[i]) begin
      wr({OP_WR_NVCFG, nv[i][7:0], nv[i][15:8], 8'h0}, 3);
      wait_ready();
      check("mode", 8'(mode), 8'(u_host.mode_q));
      @(posedge sys_clk_in);
      soft_boot_in <= 1'b1;
      ticks(4);
      soft_boot_in <= 1'b0;
      ticks(8);
      check("mode", 8'(mode), 8'(bm[i]));
      check("dummy", 8'(dummy), 8'h0f);
      follow(bm[i]);
    end
    $display("test boot done");
    wr({OP_WR_NVCFG, 24'hffff00}, 3);
    wait_ready();
    cmd({OP_WR_ENABLE, 24'h0}, 1);
    @(posedge sys_clk_in);
    sys_rst_in <= 1'b1;
    ticks(8);
    sys_rst_in <= 1'b0;
    ticks(4);
    check("mode", 8'(mode), 8'h00);
    u_host.mode_q = SFPS_MODE_EXT;
    rdsr();
    check("status", st & 8'h03, 8'h00);
    $display("test reset done");
    give_verdict();
  end
endmodule : serial_flash_protocol_status_tb
